// [sleep_wakeup_pkg.sv]
// Constants for the sleep / wake-up sequencer and its two IO ports.
// Assumes a 50 MHz system clock and an Avalon-MM register slave.
package sleep_wakeup_pkg;
  // Register word addresses (byte address = 4 * index)
  localparam logic [3:0] ADDR_PA_DATA = 4'h0;
  localparam logic [3:0] ADDR_PA_DIR = 4'h1;
  localparam logic [3:0] ADDR_PA_PULLUP = 4'h2;
  localparam logic [3:0] ADDR_PA_PULLDN = 4'h3;
  localparam logic [3:0] ADDR_PA_DIGEN = 4'h4;
  localparam logic [3:0] ADDR_PB_DATA = 4'h5;
  localparam logic [3:0] ADDR_PB_DIR = 4'h6;
  localparam logic [3:0] ADDR_PB_PULLUP = 4'h7;
  localparam logic [3:0] ADDR_PB_PULLDN = 4'h8;
  localparam logic [3:0] ADDR_PB_DIGEN = 4'h9;
  localparam logic [3:0] ADDR_AUX_CTRL = 4'hA;
  localparam logic [3:0] ADDR_SLEEP_CMD = 4'hB;
  localparam logic [3:0] ADDR_STATUS = 4'hC;
  // Field positions
  localparam int FAST_WAKE_BIT = 5;
  localparam int CMD_DEEP_BIT = 0;
  localparam int CMD_LIGHT_BIT = 1;
  // Reset values
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [7:0] AUX_RESET = 8'h00;
  // Open-drain pin on port A
  localparam int OPEN_DRAIN_BIT = 5;
  // Wake-up delays in slow oscillator periods
  localparam logic [11:0] WAKE_NORMAL_CNT = 12'd3000;
  localparam logic [11:0] WAKE_FAST_CNT = 12'd45;
  // Restart address after reset
  localparam logic [15:0] RESTART_ADDR = 16'h0000;

  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_LIGHT = 4'b0010,
    ST_DEEP = 4'b0100,
    ST_WAKE = 4'b1000
  } sleep_state_e;
endpackage : sleep_wakeup_pkg

// [sleep_wakeup_io_port_ctrl.sv]
// Sleep / wake-up sequencer with two 8-bit GPIO ports and wake-up timer.
// Assumes a free-running slow oscillator tick input sampled on clk_i.
`timescale 1ns/10ps

module sleep_wakeup_io_port_ctrl #(
  parameter logic [1:0] LVR_LEVEL = 2'h0,
  parameter logic FAST_BOOT = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic slow_osc_tick_i,
  input wire logic timer_wake_i,
  input wire logic comparator_wake_i,
  input wire logic [7:0] port_a_pad_i,
  input wire logic [7:0] port_b_pad_i,
  output logic [7:0] port_a_out_o,
  output logic [7:0] port_a_oe_o,
  output logic [7:0] port_a_pullup_o,
  output logic [7:0] port_a_pulldn_o,
  output logic [7:0] port_b_out_o,
  output logic [7:0] port_b_oe_o,
  output logic [7:0] port_b_pullup_o,
  output logic [7:0] port_b_pulldn_o,
  output logic fast_osc_en_o,
  output logic slow_osc_en_o,
  output logic ext_osc_en_o,
  output logic prog_mem_en_o,
  output logic cpu_clk_en_o,
  output logic [15:0] restart_addr_o,
  output logic [1:0] lvr_level_o
);

  typedef struct packed {
    sleep_wakeup_pkg::sleep_state_e state;
    logic [7:0] pa_data, pa_dir, pa_pu, pa_pd, pa_dien;
    logic [7:0] pb_data, pb_dir, pb_pu, pb_pd, pb_dien;
    logic [7:0] aux;
    logic [7:0] pa_s1, pa_s2, pa_s3;
    logic [7:0] pb_s1, pb_s2, pb_s3;
    logic [2:0] tick_s;
    logic [7:0] pa_flt, pb_flt; // Accepted pad levels after the agreement filter
    logic tick_flt; // Accepted slow oscillator level
    logic [11:0] wake_cnt;
    logic [11:0] wake_lim;
    logic ack;
    logic [31:0] rdata;
  } state_s;

  state_s q, d;
  logic [7:0] pa_pad, pb_pad, pa_chg, pb_chg;
  logic pin_wake, tick_rise, rd_hit;

  // Filter step: a bit takes the third stage's level once stages two and three agree
  function automatic logic [7:0] agree_take(input logic [7:0] s2, input logic [7:0] s3,
                                            input logic [7:0] old);
    agree_take = (s3 & ~(s2 ^ s3)) | (old & (s2 ^ s3));
  endfunction : agree_take

  // One-cycle pulse where an agreed level differs from the accepted one; a glitch
  // shorter than two samples never shows in stages two and three together
  function automatic logic [7:0] agree_change(input logic [7:0] s2, input logic [7:0] s3,
                                              input logic [7:0] flt);
    agree_change = ~(s2 ^ s3) & (s3 ^ flt);
  endfunction : agree_change

  // Pad view after filter; a change counts once stages two and three agree
  assign pa_pad = q.pa_flt;
  assign pb_pad = q.pb_flt;
  assign pa_chg = agree_change(q.pa_s2, q.pa_s3, q.pa_flt) & q.pa_dien & ~q.pa_dir;
  assign pb_chg = agree_change(q.pb_s2, q.pb_s3, q.pb_flt) & q.pb_dien & ~q.pb_dir;
  assign pin_wake = |{pa_chg, pb_chg};
  // Slow tick edge, taken on the same agreement rule
  assign tick_rise = q.tick_s[1] & q.tick_s[2] & ~q.tick_flt;

  // Mixed read value: pad for inputs, register for outputs
  function automatic logic [7:0] port_read(input logic [7:0] dat, input logic [7:0] dir,
                                           input logic [7:0] pad);
    port_read = (dat & dir) | (pad & ~dir);
  endfunction : port_read

  // Next state: bus slave, sleep sequencer and wake timer
  always_comb begin
    d = q;
    d.pa_s1 = port_a_pad_i;
    d.pa_s2 = q.pa_s1;
    d.pa_s3 = q.pa_s2;
    d.pb_s1 = port_b_pad_i;
    d.pb_s2 = q.pb_s1;
    d.pb_s3 = q.pb_s2;
    d.tick_s = {q.tick_s[1:0], slow_osc_tick_i};
    // Accepted levels move only where stages two and three agree
    d.pa_flt = agree_take(q.pa_s2, q.pa_s3, q.pa_flt);
    d.pb_flt = agree_take(q.pb_s2, q.pb_s3, q.pb_flt);
    d.tick_flt = (q.tick_s[1] == q.tick_s[2]) ? q.tick_s[2] : q.tick_flt;
    rd_hit = avs_read_i & ~q.ack;
    // One wait cycle per access keeps read data registered
    d.ack = (avs_read_i | avs_write_i) & ~q.ack;
    if (rd_hit) begin
      unique case (avs_address_i)
        sleep_wakeup_pkg::ADDR_PA_DATA: d.rdata = {24'h0, port_read(q.pa_data, q.pa_dir, pa_pad)};
        sleep_wakeup_pkg::ADDR_PA_DIR: d.rdata = {24'h0, q.pa_dir};
        sleep_wakeup_pkg::ADDR_PA_PULLUP: d.rdata = {24'h0, q.pa_pu};
        sleep_wakeup_pkg::ADDR_PA_PULLDN: d.rdata = {24'h0, q.pa_pd};
        sleep_wakeup_pkg::ADDR_PA_DIGEN: d.rdata = {24'h0, q.pa_dien};
        sleep_wakeup_pkg::ADDR_PB_DATA: d.rdata = {24'h0, port_read(q.pb_data, q.pb_dir, pb_pad)};
        sleep_wakeup_pkg::ADDR_PB_DIR: d.rdata = {24'h0, q.pb_dir};
        sleep_wakeup_pkg::ADDR_PB_PULLUP: d.rdata = {24'h0, q.pb_pu};
        sleep_wakeup_pkg::ADDR_PB_PULLDN: d.rdata = {24'h0, q.pb_pd};
        sleep_wakeup_pkg::ADDR_PB_DIGEN: d.rdata = {24'h0, q.pb_dien};
        sleep_wakeup_pkg::ADDR_AUX_CTRL: d.rdata = {24'h0, q.aux};
        sleep_wakeup_pkg::ADDR_STATUS: d.rdata = {28'h0, q.state};
        default: d.rdata = 32'h0; // Unmapped and command reads give zero
      endcase
    end
    // Writes land only on the acknowledging cycle
    if (avs_write_i & q.ack & avs_byteenable_i[0]) begin
      unique case (avs_address_i)
        sleep_wakeup_pkg::ADDR_PA_DATA: d.pa_data = avs_writedata_i[7:0];
        sleep_wakeup_pkg::ADDR_PA_DIR: d.pa_dir = avs_writedata_i[7:0];
        sleep_wakeup_pkg::ADDR_PA_PULLUP: d.pa_pu = avs_writedata_i[7:0];
        sleep_wakeup_pkg::ADDR_PA_PULLDN: d.pa_pd = avs_writedata_i[7:0];
        sleep_wakeup_pkg::ADDR_PA_DIGEN: d.pa_dien = avs_writedata_i[7:0];
        sleep_wakeup_pkg::ADDR_PB_DATA: d.pb_data = avs_writedata_i[7:0];
        sleep_wakeup_pkg::ADDR_PB_DIR: d.pb_dir = avs_writedata_i[7:0];
        sleep_wakeup_pkg::ADDR_PB_PULLUP: d.pb_pu = avs_writedata_i[7:0];
        sleep_wakeup_pkg::ADDR_PB_PULLDN: d.pb_pd = avs_writedata_i[7:0];
        sleep_wakeup_pkg::ADDR_PB_DIGEN: d.pb_dien = avs_writedata_i[7:0];
        sleep_wakeup_pkg::ADDR_AUX_CTRL: d.aux = avs_writedata_i[7:0];
        sleep_wakeup_pkg::ADDR_SLEEP_CMD: begin
          if (q.state == sleep_wakeup_pkg::ST_RUN) begin
            if (avs_writedata_i[sleep_wakeup_pkg::CMD_DEEP_BIT]) begin
              d.state = sleep_wakeup_pkg::ST_DEEP;
            end else if (avs_writedata_i[sleep_wakeup_pkg::CMD_LIGHT_BIT]) begin
              d.state = sleep_wakeup_pkg::ST_LIGHT;
            end
          end
        end
        default: ;
      endcase
    end
    // Sleep sequencer; registers untouched, CPU just resumes
    unique case (q.state)
      sleep_wakeup_pkg::ST_RUN: ;
      sleep_wakeup_pkg::ST_LIGHT: begin
        if (pin_wake | timer_wake_i | comparator_wake_i) begin
          d.state = sleep_wakeup_pkg::ST_WAKE;
        end
      end
      sleep_wakeup_pkg::ST_DEEP: begin
        if (pin_wake) begin
          d.state = sleep_wakeup_pkg::ST_WAKE;
        end
      end
      sleep_wakeup_pkg::ST_WAKE: begin
        if (tick_rise) begin
          d.wake_cnt = q.wake_cnt + 12'd1;
        end
        if (q.wake_cnt >= q.wake_lim) begin
          d.state = sleep_wakeup_pkg::ST_RUN;
        end
      end
      default: d.state = sleep_wakeup_pkg::ST_RUN;
    endcase
    // Latch delay choice at the wake event
    if (q.state != sleep_wakeup_pkg::ST_WAKE) begin
      d.wake_cnt = 12'd0;
      d.wake_lim = (FAST_BOOT | q.aux[sleep_wakeup_pkg::FAST_WAKE_BIT]) ?
                   sleep_wakeup_pkg::WAKE_FAST_CNT : sleep_wakeup_pkg::WAKE_NORMAL_CNT;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '{state: sleep_wakeup_pkg::ST_RUN, aux: sleep_wakeup_pkg::AUX_RESET,
             wake_lim: sleep_wakeup_pkg::WAKE_NORMAL_CNT, default: '0};
    end else begin
      q <= d;
    end
  end

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~q.ack;
  assign avs_readdata_o = q.rdata;

  assign port_a_out_o = q.pa_data;
  assign port_b_out_o = q.pb_data;
  assign port_a_oe_o = q.pa_dir & ~(q.pa_data & (8'h01 << sleep_wakeup_pkg::OPEN_DRAIN_BIT));
  assign port_b_oe_o = q.pb_dir;
  assign port_a_pullup_o = q.pa_pu & ~q.pa_dir;
  assign port_a_pulldn_o = q.pa_pd & ~q.pa_dir;
  assign port_b_pullup_o = q.pb_pu & ~q.pb_dir;
  assign port_b_pulldn_o = q.pb_pd & ~q.pb_dir;

  assign fast_osc_en_o = q.state != sleep_wakeup_pkg::ST_DEEP;
  assign ext_osc_en_o = q.state != sleep_wakeup_pkg::ST_DEEP;
  assign slow_osc_en_o = q.state != sleep_wakeup_pkg::ST_DEEP;
  assign prog_mem_en_o = q.state == sleep_wakeup_pkg::ST_RUN;
  assign cpu_clk_en_o = q.state == sleep_wakeup_pkg::ST_RUN;
  // restart vector; memory is never cleared here
  assign restart_addr_o = sleep_wakeup_pkg::RESTART_ADDR;
  assign lvr_level_o = LVR_LEVEL;

  // timer alone does not wake deep sleep
  AST_DEEP_NO_TIMER: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (q.state == sleep_wakeup_pkg::ST_DEEP) && !pin_wake |=> q.state == sleep_wakeup_pkg::ST_DEEP)
    else $error("deep sleep left without pin event");
  AST_LIGHT_TIMER_WAKE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (q.state == sleep_wakeup_pkg::ST_LIGHT) && timer_wake_i |=> q.state == sleep_wakeup_pkg::ST_WAKE)
    else $error("light sleep ignored timer wake");
  AST_DEEP_OSC_OFF: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (q.state == sleep_wakeup_pkg::ST_DEEP) |-> !fast_osc_en_o && !slow_osc_en_o && !prog_mem_en_o)
    else $error("oscillators running in deep sleep");
  AST_LIGHT_OSC_ON: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (q.state == sleep_wakeup_pkg::ST_LIGHT) |-> fast_osc_en_o && slow_osc_en_o && !cpu_clk_en_o)
    else $error("light sleep gating wrong");
  AST_WAKE_LIMIT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(q.state == sleep_wakeup_pkg::ST_WAKE) && $past(q.aux[5]) |->
      q.wake_lim == sleep_wakeup_pkg::WAKE_FAST_CNT)
    else $error("fast wake not selected");
  AST_WAKE_END: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (q.state == sleep_wakeup_pkg::ST_WAKE) && (q.wake_cnt >= q.wake_lim) |=>
      q.state == sleep_wakeup_pkg::ST_RUN)
    else $error("wake timer did not release cpu");
  AST_PULL_OFF_OUT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ((port_a_pullup_o | port_a_pulldn_o) & q.pa_dir) == 8'h00)
    else $error("pull active on output pin");
  AST_OPEN_DRAIN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(port_a_oe_o[5] && port_a_out_o[5]))
    else $error("open drain pin driven high");
  AST_READ_SRC: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    avs_read_i && !q.ack && avs_address_i == sleep_wakeup_pkg::ADDR_PA_DATA |=>
      (q.rdata[7:0] & $past(q.pa_dir)) == ($past(q.pa_data) & $past(q.pa_dir)))
    else $error("output pin read not from register");

  AST_LIGHT_CMP_WAKE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (q.state == sleep_wakeup_pkg::ST_LIGHT) && comparator_wake_i |=>
      q.state == sleep_wakeup_pkg::ST_WAKE)
    else $error("light sleep ignored comparator wake");
  AST_DEEP_PIN_WAKE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (q.state == sleep_wakeup_pkg::ST_DEEP) && pin_wake |=>
      q.state == sleep_wakeup_pkg::ST_WAKE)
    else $error("deep sleep ignored pin wake");
  // delay choice, no early release, plain resume
  AST_WAKE_NORMAL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(q.state == sleep_wakeup_pkg::ST_WAKE) && !$past(q.aux[5]) && !FAST_BOOT |->
      q.wake_lim == sleep_wakeup_pkg::WAKE_NORMAL_CNT)
    else $error("normal wake delay not selected");
  AST_WAKE_EARLY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (q.state == sleep_wakeup_pkg::ST_WAKE) && (q.wake_cnt < q.wake_lim) |=>
      q.state == sleep_wakeup_pkg::ST_WAKE)
    else $error("cpu released before wake delay");
  AST_RESUME_RUN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(q.state == sleep_wakeup_pkg::ST_WAKE) |->
      (q.state == sleep_wakeup_pkg::ST_RUN) && cpu_clk_en_o && prog_mem_en_o)
    else $error("wake did not resume execution");
  AST_OD_DRIVES_LOW: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    q.pa_dir[5] && !q.pa_data[5] |-> port_a_oe_o[5] && !port_a_out_o[5])
    else $error("open drain pin not driving low");
  AST_PULL_BY_LEVEL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ((port_b_pullup_o & port_b_oe_o & ~port_b_out_o) |
     (port_b_pulldn_o & port_b_oe_o & port_b_out_o)) == 8'h00)
    else $error("pull fights driven level");

endmodule : sleep_wakeup_io_port_ctrl

// [pad_world.sv]
// Far-side model: pad levels of both ports and the slow oscillator.
// Assumes the bench supplies the level that each outside source drives.
`timescale 1ns/10ps
module pad_world (
  input wire logic clk_i,
  input wire logic slow_osc_en_i,
  input wire logic [7:0] a_out_i,
  input wire logic [7:0] a_oe_i,
  input wire logic [7:0] b_out_i,
  input wire logic [7:0] b_oe_i,
  input wire logic [7:0] a_ext_i,
  input wire logic [7:0] b_ext_i,
  output logic [7:0] a_pad_o,
  output logic [7:0] b_pad_o,
  output logic slow_tick_o
);
  logic [1:0] div_q = 2'h0;
  // Driven pins show the port, others the outside source, which outweighs a pull
  assign a_pad_o = (a_oe_i & a_out_i) | (~a_oe_i & a_ext_i);
  assign b_pad_o = (b_oe_i & b_out_i) | (~b_oe_i & b_ext_i);
  // Slow clock stands still while its oscillator is off
  always_ff @(posedge clk_i) begin
    if (slow_osc_en_i) begin
      div_q <= div_q + 2'h1;
    end
  end
  assign slow_tick_o = div_q[1];
endmodule : pad_world

// [test_sleep_wakeup_io_port_ctrl.sv]
// Self-checking bench for the sleep / wake-up sequencer and its ports.
// Assumes one wait cycle on the register bus and a slow tick of four clocks.
`timescale 1ns/10ps
module test_sleep_wakeup_io_port_ctrl;
  logic clk_i, rst_n_i, avs_read_i, avs_write_i, slow_osc_tick_i, timer_wake_i;
  logic comparator_wake_i, avs_waitrequest_o, fast_osc_en_o, slow_osc_en_o, ext_osc_en_o;
  logic prog_mem_en_o, cpu_clk_en_o, tick_q;
  logic [3:0] avs_address_i, avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  logic [7:0] port_a_pad_i, port_b_pad_i, port_a_out_o, port_a_oe_o, port_a_pullup_o;
  logic [7:0] port_a_pulldn_o, port_b_out_o, port_b_oe_o, port_b_pullup_o, port_b_pulldn_o;
  logic [7:0] a_ext, b_ext, dir, dat, pu, pd;
  logic [15:0] restart_addr_o;
  logic [1:0] lvr_level_o;
  int n_fail = 0, n_checks = 0, cyc = 0, ticks = 0;
  sleep_wakeup_io_port_ctrl #(.LVR_LEVEL(2'h2), .FAST_BOOT(1'b0)) dut (.clk_i, .rst_n_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
    .avs_readdata_o, .avs_waitrequest_o, .slow_osc_tick_i, .timer_wake_i, .comparator_wake_i,
    .port_a_pad_i, .port_b_pad_i, .port_a_out_o, .port_a_oe_o, .port_a_pullup_o,
    .port_a_pulldn_o, .port_b_out_o, .port_b_oe_o, .port_b_pullup_o, .port_b_pulldn_o,
    .fast_osc_en_o, .slow_osc_en_o, .ext_osc_en_o, .prog_mem_en_o, .cpu_clk_en_o,
    .restart_addr_o, .lvr_level_o);
  pad_world far (.clk_i, .slow_osc_en_i(slow_osc_en_o), .a_out_i(port_a_out_o),
    .a_oe_i(port_a_oe_o), .b_out_i(port_b_out_o), .b_oe_i(port_b_oe_o), .a_ext_i(a_ext),
    .b_ext_i(b_ext), .a_pad_o(port_a_pad_i), .b_pad_o(port_b_pad_i),
    .slow_tick_o(slow_osc_tick_i));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // Tick counter for wake delays; the ceiling cuts a hang short
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    tick_q <= slow_osc_tick_i;
    if (slow_osc_tick_i && !tick_q) ticks <= ticks + 1;
    if (cyc == 40000) begin
      n_fail++;
      end_sim();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task end_sim();
    if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  // One bus cycle, held until waitrequest is sampled low
  task bus(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= {24'h0, d};
    avs_byteenable_i <= be;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus
  task rdchk(input logic [3:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00, 4'hF);
    chk(rd, {24'h0, exp});
  endtask : rdchk
  task wake_within(input int lo, input int hi);
    int t0;
    t0 = ticks;
    while (cpu_clk_en_o !== 1'b1) @(posedge clk_i);
    chk({31'h0, (ticks - t0) >= lo && (ticks - t0) <= hi}, 32'h1);
  endtask : wake_within
  function automatic logic [7:0] exp_oe(input logic [7:0] di, da, input logic od);
    exp_oe = di & ~{2'h0, od & da[5], 5'h0};
  endfunction : exp_oe
  initial begin
    {rst_n_i, avs_read_i, avs_write_i, timer_wake_i, comparator_wake_i} = 5'h00;
    {avs_address_i, avs_byteenable_i, avs_writedata_i, a_ext, b_ext} = 56'h0;
    void'($urandom(32'hE89A));
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 14; i++) begin
      if (i != 11) rdchk(i[3:0], (i == 12) ? 8'h01 : 8'h00);
    end
    chk({16'h0, restart_addr_o}, 32'h0);
    chk({30'h0, lvr_level_o}, 32'h2);
    for (int k = 0; k < 8; k++) begin
      {dir, dat, pu, pd} = $urandom();
      if (k == 0) dir = 8'hFF;
      a_ext <= 8'($urandom());
      b_ext <= 8'($urandom());
      for (int p = 0; p < 2; p++) begin
        bus(1'b1, 4'(p * 5), dat, 4'hF);
        bus(1'b1, 4'(p * 5 + 1), dir, 4'hF);
        bus(1'b1, 4'(p * 5 + 1), ~dir, 4'hE);
        bus(1'b1, 4'(p * 5 + 2), pu, 4'hF);
        bus(1'b1, 4'(p * 5 + 3), pd, 4'hF);
      end
      bus(1'b1, 4'hD, 8'hFF, 4'hF);
      repeat (6) @(posedge clk_i);
      chk({24'h0, port_a_oe_o}, {24'h0, exp_oe(dir, dat, 1'b1)});
      chk({24'h0, port_b_oe_o}, {24'h0, exp_oe(dir, dat, 1'b0)});
      chk({port_a_out_o, port_b_out_o}, {2{dat}});
      chk({port_a_pullup_o, port_b_pullup_o}, {2{pu & ~dir}});
      chk({port_a_pulldn_o, port_b_pulldn_o}, {2{pd & ~dir}});
      rdchk(sleep_wakeup_pkg::ADDR_PA_DATA, (dir & dat) | (~dir & a_ext));
      rdchk(sleep_wakeup_pkg::ADDR_PB_DIR, dir);
      rdchk(4'hD, 8'h00);
    end
    // wake pins are inputs with digital input on
    bus(1'b1, sleep_wakeup_pkg::ADDR_PA_DIR, 8'h00, 4'hF);
    bus(1'b1, sleep_wakeup_pkg::ADDR_PB_DIR, 8'h00, 4'hF);
    // interrupt pins enabled, analog pins left off
    bus(1'b1, sleep_wakeup_pkg::ADDR_PA_DIGEN, 8'h11, 4'hF);
    bus(1'b1, sleep_wakeup_pkg::ADDR_PB_DIGEN, 8'h21, 4'hF);
    bus(1'b1, sleep_wakeup_pkg::ADDR_AUX_CTRL, 8'h20, 4'hF);
    // Light sleep left by timer, comparator, then pin
    for (int s = 0; s < 3; s++) begin
      bus(1'b1, sleep_wakeup_pkg::ADDR_SLEEP_CMD, 8'h02, 4'hF);
      repeat (4) @(posedge clk_i);
      chk({cpu_clk_en_o, prog_mem_en_o, fast_osc_en_o, slow_osc_en_o, ext_osc_en_o},
          5'h07);
      // A sleep command while asleep is refused
      if (s == 0) bus(1'b1, sleep_wakeup_pkg::ADDR_SLEEP_CMD, 8'h01, 4'hF);
      rdchk(sleep_wakeup_pkg::ADDR_STATUS, 8'h02);
      if (s == 0) timer_wake_i <= 1'b1;
      if (s == 1) comparator_wake_i <= 1'b1;
      if (s == 2) b_ext <= b_ext ^ 8'h20;
      wake_within(44, 49);
      {timer_wake_i, comparator_wake_i} <= 2'h0;
      rdchk(sleep_wakeup_pkg::ADDR_STATUS, 8'h01);
    end
    rdchk(sleep_wakeup_pkg::ADDR_AUX_CTRL, 8'h20);
    bus(1'b1, sleep_wakeup_pkg::ADDR_AUX_CTRL, 8'h00, 4'hF);
    // timer, comparator and a pin without digital input do not wake deep sleep
    bus(1'b1, sleep_wakeup_pkg::ADDR_SLEEP_CMD, 8'h01, 4'hF);
    repeat (4) @(posedge clk_i);
    chk({cpu_clk_en_o, prog_mem_en_o, fast_osc_en_o, slow_osc_en_o, ext_osc_en_o}, 5'h00);
    rdchk(sleep_wakeup_pkg::ADDR_STATUS, 8'h04);
    {timer_wake_i, comparator_wake_i} <= 2'h3;
    a_ext <= a_ext ^ 8'h02;
    repeat (50) @(posedge clk_i);
    chk({31'h0, cpu_clk_en_o}, 32'h0);
    a_ext <= a_ext ^ 8'h01;
    wake_within(2995, 3005);
    {timer_wake_i, comparator_wake_i} <= 2'h0;
    rdchk(sleep_wakeup_pkg::ADDR_STATUS, 8'h01);
    rdchk(sleep_wakeup_pkg::ADDR_PB_DIGEN, 8'h21);
    // both command bits give deep sleep; fast wake from it on a pin
    bus(1'b1, sleep_wakeup_pkg::ADDR_AUX_CTRL, 8'h20, 4'hF);
    bus(1'b1, sleep_wakeup_pkg::ADDR_SLEEP_CMD, 8'h03, 4'hF);
    rdchk(sleep_wakeup_pkg::ADDR_STATUS, 8'h04);
    a_ext <= a_ext ^ 8'h10;
    wake_within(44, 49);
    rdchk(sleep_wakeup_pkg::ADDR_STATUS, 8'h01);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rdchk(sleep_wakeup_pkg::ADDR_PB_DIGEN, 8'h00);
    end_sim();
  end
endmodule : test_sleep_wakeup_io_port_ctrl
